/* verilog/fedi_defs.svh */
// Register map, field positions and timing constants of the event and interrupt block.
`ifndef FEDI_DEFS_SVH
`define FEDI_DEFS_SVH

// ****************************************************************************
// Register pages and addresses
// ****************************************************************************
`define FEDI_PAGE_CTL 4'h1
`define FEDI_PAGE_STAT 4'h3
`define FEDI_PAGE_LATCH 4'h4
`define FEDI_PAGE_HDLC 4'hB
`define FEDI_ADDR_RESET_CTL 5'h1A
`define FEDI_ADDR_MASK0 5'h1B
`define FEDI_ADDR_MASK1 5'h1C
`define FEDI_ADDR_MASK2 5'h1D
`define FEDI_ADDR_MASK3 5'h1E
`define FEDI_ADDR_HDLC_MASK 5'h16
`define FEDI_ADDR_HDLC_INT 5'h17
`define FEDI_ADDR_SYNC_STAT 5'h10
`define FEDI_ADDR_ALARM_STAT 5'h11
`define FEDI_ADDR_FAS_WORD 5'h12
`define FEDI_ADDR_NFAS_MFAS 5'h13
`define FEDI_ADDR_ALARM_LATCH 5'h12
`define FEDI_ADDR_INT0 5'h13
`define FEDI_ADDR_INT1 5'h14
`define FEDI_ADDR_INT2 5'h15
`define FEDI_ADDR_INT3 5'h16

// ****************************************************************************
// Field positions and reset values
// ****************************************************************************
`define FEDI_CTL_RST 7
`define FEDI_CTL_INTERRUPT_SUSPEND_BIT 6
`define FEDI_CTL_INTERRUPT_ACKNOWLEDGE_BIT 5
`define FEDI_SYNC_SEF 5
`define FEDI_ALM_LOOPBACK_DISABLE_DETECTED 0
`define FEDI_ALM_LOOPBACK_ENABLE_DETECTED 1
`define FEDI_ALM_PDV 2
`define FEDI_W0_SEI 2
`define FEDI_W1_DENSITY_VIOLATION_INT 0
`define FEDI_W3_LCDI 4
`define FEDI_W3_ONESEC 3
`define FEDI_RESET_BYTE 8'h00
`define FEDI_FAS_PATTERN 7'h1B

// ****************************************************************************
// Pattern and timing figures
// ****************************************************************************
`define FEDI_CLK_HZ 20000000
`define FEDI_ONE_SEC_S 1
`define FEDI_LOOP_PERSIST_MS 48
`define FEDI_MS_PER_S 1000
`define FEDI_SEF_WINDOW 6
`define FEDI_DENS_RUN 16
`define FEDI_DENS_MAX_N 23
`define FEDI_LOOP_ON_PERIOD 5
`define FEDI_LOOP_OFF_PERIOD 3

`endif

/* verilog/fedi_pkg.sv */
// Types shared by the event and interrupt block.
package fedi_pkg;

  typedef logic [7:0] fedi_byte_t;

  typedef logic [4:0][7:0] fedi_words_t;

  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [3:0] page;
    logic [4:0] addr;
    logic [7:0] wdata;
  } fedi_bus_req_s;

  typedef struct packed {
    logic valid;
    logic data;
    logic fbit;
  } fedi_line_s;

  typedef struct packed {
    logic valid;
    logic error;
  } fedi_fbit_s;

  typedef struct packed {
    logic ts0_valid;
    logic fas_frame;
    logic [7:0] ts0_byte;
    logic ts16_valid;
    logic [7:0] ts16_byte;
  } fedi_e1_s;

endpackage : fedi_pkg

/* verilog/fedi_loop_det.sv */
// Repeating one-in-PERIOD loop code detector with a persistence timer.
`timescale 1ns/1ps
`default_nettype none
`include "fedi_defs.svh"

module fedi_loop_det #(
  parameter int unsigned PERIOD = `FEDI_LOOP_ON_PERIOD,
  parameter int unsigned PERSIST = 960000
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic bit_valid,
  input wire logic bit_in,
  input wire logic skip,
  output logic detected
);

  localparam int unsigned CW = $clog2(PERSIST + 1);

  logic [PERIOD-1:0] window;
  logic [CW-1:0] persist_cnt;
  logic in_pattern;

  // ****************************************************************************
  // A sliding window that stays one-hot can only hold a repeating 0..01 code.
  // ****************************************************************************
  assign in_pattern = $onehot(window);

  always_ff @(posedge clk) begin
    if (reset) begin
      window <= '0;
    end else if (bit_valid && !skip) begin
      window <= {window[PERIOD-2:0], bit_in};
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !in_pattern) begin
      persist_cnt <= '0;
      detected <= 1'b0;
    end else if (persist_cnt == CW'(PERSIST)) begin
      detected <= 1'b1;
    end else begin
      persist_cnt <= persist_cnt + CW'(1);
    end
  end

endmodule : fedi_loop_det

`default_nettype wire

/* verilog/fedi_event_irq.sv */
// Receive event detection and maskable interrupt logic of the framer.
// Functional notes
// - T1: toggle errored-frame bit on two framing errors within six framing bits.
// - T1: recognise framed or unframed 00001 activate and 001 deactivate loop codes.
// - Set loopback disable detected after 001 code persists 48 ms.
// - Set loopback enable detected after 00001 code persists 48 ms.
// - T1: toggle density violation flag on sixteen consecutive zeros.
// - Toggle density flag when 8(N+1) bits hold under N ones, N 1..23.
// - Keep a one-second timer from the 20 MHz clock raising interrupts.
// - E1: flag event when two alignment words in a row are errored.
// - E1: take timeslot zero bits two to eight, compare with 0011011.
// - E1: extract non-alignment bit two of timeslot zero.
// - E1: extract bits one to four of timeslot sixteen, frame zero.
// - Each source has mask and interrupt bit; unmasked event pulls request low.
// - Reading an interrupt register clears it.
// - With all interrupt registers clear the request output floats.
// - Toggling the acknowledge bit clears interrupts and releases the request.
// - Four mask words at 1BH..1EH plus a separate HDLC mask.
// - Reset pin or reset bit masks every interrupt source.
// - Suspend bit suppresses interrupts without touching mask words.
// - Transmit all ones pin low clears every pending interrupt.
// - Alarm latch bits set on alarms and hold until read.
`timescale 1ns/1ps
`default_nettype none
`include "fedi_defs.svh"

module fedi_event_irq #(
  parameter int unsigned ONE_SEC_CYCLES = `FEDI_CLK_HZ * `FEDI_ONE_SEC_S,
  parameter int unsigned LOOP_PERSIST_CYCLES =
    (`FEDI_CLK_HZ / `FEDI_MS_PER_S) * `FEDI_LOOP_PERSIST_MS,
  parameter int unsigned SEF_WINDOW = `FEDI_SEF_WINDOW,
  parameter int unsigned DENS_RUN = `FEDI_DENS_RUN,
  parameter int unsigned DENS_MAX_N = `FEDI_DENS_MAX_N
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic e1_mode,
  input wire fedi_pkg::fedi_bus_req_s bus,
  input wire fedi_pkg::fedi_line_s line,
  input wire fedi_pkg::fedi_fbit_s t1_fbit,
  input wire fedi_pkg::fedi_e1_s e1,
  input wire fedi_pkg::fedi_words_t ext_events,
  input wire logic [7:0] alarm_levels,
  input wire logic transmit_all_ones_pin_n,
  output logic [7:0] bus_rdata,
  output logic irq_n_out,
  output logic irq_oe
);

  localparam int unsigned NW = 5;
  localparam int unsigned SEC_W = $clog2(ONE_SEC_CYCLES);
  localparam logic [3:0] MASK_PAGE [NW] = '{`FEDI_PAGE_CTL, `FEDI_PAGE_CTL,
    `FEDI_PAGE_CTL, `FEDI_PAGE_CTL, `FEDI_PAGE_HDLC};
  localparam logic [4:0] MASK_ADDR [NW] = '{`FEDI_ADDR_MASK0, `FEDI_ADDR_MASK1,
    `FEDI_ADDR_MASK2, `FEDI_ADDR_MASK3, `FEDI_ADDR_HDLC_MASK};
  localparam logic [3:0] INT_PAGE [NW] = '{`FEDI_PAGE_LATCH, `FEDI_PAGE_LATCH,
    `FEDI_PAGE_LATCH, `FEDI_PAGE_LATCH, `FEDI_PAGE_HDLC};
  localparam logic [4:0] INT_ADDR [NW] = '{`FEDI_ADDR_INT0, `FEDI_ADDR_INT1,
    `FEDI_ADDR_INT2, `FEDI_ADDR_INT3, `FEDI_ADDR_HDLC_INT};

  logic transmit_all_ones_pin_meta;
  logic transmit_all_ones_pin_sync;
  logic [7:0] ctl_reg;
  logic interrupt_acknowledge_bit_prev;
  logic soft_rst;
  logic interrupt_suspend_bit;
  logic rd_hit;
  logic wr_hit;
  logic [7:0] mask_reg [NW];
  logic [7:0] int_reg [NW];
  logic [7:0] next_int [NW];
  logic [NW-1:0] rd_int;
  logic [7:0] next_rdata;
  logic [7:0] alarm_latch;
  logic [SEF_WINDOW-2:0] fb_hist;
  logic sef_toggle;
  logic sef_event;
  logic [7:0] one_age [DENS_MAX_N];
  logic [7:0] bits_seen;
  logic [4:0] zero_run;
  logic [DENS_MAX_N:0] viol_vec;
  logic viol_prev;
  logic pdv_toggle;
  logic pdv_event;
  logic off_u;
  logic off_f;
  logic on_u;
  logic on_f;
  logic loopback_disable_detected;
  logic loopback_enable_detected;
  logic lcd_event;
  logic [SEC_W-1:0] sec_cnt;
  logic one_sec_event;
  logic [6:0] fas_word;
  logic fas_err_prev;
  logic consec_err;
  logic consecutive_alignment_error_event;
  logic nfas_bit;
  logic [3:0] mfas_bits;
  logic t1_bit;
  fedi_pkg::fedi_words_t ev_own;

  function automatic logic [7:0] sat_inc(input logic [7:0] a);
    sat_inc = (a == 8'hFF) ? a : a + 8'h01;
  endfunction : sat_inc

  // ****************************************************************************
  // Pin synchroniser, control word and reset scope
  // ****************************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      transmit_all_ones_pin_meta <= 1'b1;
      transmit_all_ones_pin_sync <= 1'b1;
    end else begin
      transmit_all_ones_pin_meta <= transmit_all_ones_pin_n;
      transmit_all_ones_pin_sync <= transmit_all_ones_pin_meta;
    end
  end

  assign rd_hit = bus.cs && bus.rd;
  assign wr_hit = bus.cs && bus.wr;
  assign soft_rst = reset || ctl_reg[`FEDI_CTL_RST];
  assign interrupt_suspend_bit = ctl_reg[`FEDI_CTL_INTERRUPT_SUSPEND_BIT];
  assign t1_bit = line.valid && !e1_mode;

  always_ff @(posedge clk) begin
    if (reset) begin
      ctl_reg <= `FEDI_RESET_BYTE;
      interrupt_acknowledge_bit_prev <= 1'b0;
    end else begin
      if (wr_hit && bus.page == `FEDI_PAGE_CTL && bus.addr == `FEDI_ADDR_RESET_CTL) begin
        ctl_reg <= bus.wdata;
      end
      interrupt_acknowledge_bit_prev <= ctl_reg[`FEDI_CTL_INTERRUPT_ACKNOWLEDGE_BIT];
    end
  end

  // ****************************************************************************
  // Mask words
  // ****************************************************************************
  always_ff @(posedge clk) begin
    for (int i = 0; i < NW; i++) begin
      if (soft_rst) begin
        mask_reg[i] <= `FEDI_RESET_BYTE;
      end else if (wr_hit && bus.page == MASK_PAGE[i] && bus.addr == MASK_ADDR[i]) begin
        mask_reg[i] <= bus.wdata;
      end
    end
  end

  // ****************************************************************************
  // T1 severely errored framing
  // ****************************************************************************
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      fb_hist <= '0;
      sef_toggle <= 1'b0;
      sef_event <= 1'b0;
    end else begin
      sef_event <= 1'b0;
      if (t1_fbit.valid && !e1_mode) begin
        fb_hist <= {fb_hist[SEF_WINDOW-3:0], t1_fbit.error};
        if (t1_fbit.error && |fb_hist) begin
          sef_toggle <= !sef_toggle;
          sef_event <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************************
  // T1 pulse density: ages of the most recent ones and the zero run
  // ****************************************************************************
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      bits_seen <= '0;
      zero_run <= '0;
      for (int k = 0; k < DENS_MAX_N; k++) begin
        one_age[k] <= 8'hFF;
      end
    end else if (t1_bit) begin
      bits_seen <= sat_inc(bits_seen);
      if (line.data) begin
        zero_run <= '0;
        one_age[0] <= 8'h00;
        for (int k = 1; k < DENS_MAX_N; k++) begin
          one_age[k] <= sat_inc(one_age[k-1]);
        end
      end else begin
        if (zero_run != 5'(DENS_RUN)) begin
          zero_run <= zero_run + 5'h01;
        end
        for (int k = 0; k < DENS_MAX_N; k++) begin
          one_age[k] <= sat_inc(one_age[k]);
        end
      end
    end
  end

  assign viol_vec[0] = (zero_run == 5'(DENS_RUN));

  for (genvar n = 1; n <= DENS_MAX_N; n++) begin : g_dens
    localparam logic [7:0] WIN = 8'(8 * (n + 1));
    assign viol_vec[n] = (bits_seen >= WIN) && (sat_inc(one_age[n-1]) > WIN);
  end

  always_ff @(posedge clk) begin
    if (soft_rst) begin
      viol_prev <= 1'b0;
      pdv_toggle <= 1'b0;
      pdv_event <= 1'b0;
    end else begin
      viol_prev <= |viol_vec;
      pdv_event <= (|viol_vec) && !viol_prev && !e1_mode;
      if ((|viol_vec) && !viol_prev && !e1_mode) begin
        pdv_toggle <= !pdv_toggle;
      end
    end
  end

  // ****************************************************************************
  // T1 line loopback codes
  // ****************************************************************************
  fedi_loop_det #(.PERIOD(`FEDI_LOOP_OFF_PERIOD), .PERSIST(LOOP_PERSIST_CYCLES)) u_off_u (
    .clk(clk), .reset(soft_rst), .bit_valid(t1_bit), .bit_in(line.data),
    .skip(1'b0), .detected(off_u));
  fedi_loop_det #(.PERIOD(`FEDI_LOOP_OFF_PERIOD), .PERSIST(LOOP_PERSIST_CYCLES)) u_off_f (
    .clk(clk), .reset(soft_rst), .bit_valid(t1_bit), .bit_in(line.data),
    .skip(line.fbit), .detected(off_f));
  fedi_loop_det #(.PERIOD(`FEDI_LOOP_ON_PERIOD), .PERSIST(LOOP_PERSIST_CYCLES)) u_on_u (
    .clk(clk), .reset(soft_rst), .bit_valid(t1_bit), .bit_in(line.data),
    .skip(1'b0), .detected(on_u));
  fedi_loop_det #(.PERIOD(`FEDI_LOOP_ON_PERIOD), .PERSIST(LOOP_PERSIST_CYCLES)) u_on_f (
    .clk(clk), .reset(soft_rst), .bit_valid(t1_bit), .bit_in(line.data),
    .skip(line.fbit), .detected(on_f));

  always_ff @(posedge clk) begin
    if (soft_rst) begin
      loopback_disable_detected <= 1'b0;
      loopback_enable_detected <= 1'b0;
      lcd_event <= 1'b0;
    end else begin
      loopback_disable_detected <= off_u || off_f;
      loopback_enable_detected <= on_u || on_f;
      lcd_event <= ((off_u || off_f) && !loopback_disable_detected) || ((on_u || on_f) && !loopback_enable_detected);
    end
  end

  // ****************************************************************************
  // One-second timer
  // ****************************************************************************
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      sec_cnt <= '0;
      one_sec_event <= 1'b0;
    end else if (sec_cnt == SEC_W'(ONE_SEC_CYCLES - 1)) begin
      sec_cnt <= '0;
      one_sec_event <= 1'b1;
    end else begin
      sec_cnt <= sec_cnt + SEC_W'(1);
      one_sec_event <= 1'b0;
    end
  end

  // ****************************************************************************
  // E1 alignment signals
  // ****************************************************************************
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      fas_word <= '0;
      fas_err_prev <= 1'b0;
      consec_err <= 1'b0;
      consecutive_alignment_error_event <= 1'b0;
      nfas_bit <= 1'b0;
      mfas_bits <= '0;
    end else begin
      consecutive_alignment_error_event <= 1'b0;
      if (e1_mode && e1.ts0_valid && e1.fas_frame) begin
        fas_word <= e1.ts0_byte[6:0];
        fas_err_prev <= (e1.ts0_byte[6:0] != `FEDI_FAS_PATTERN);
        consec_err <= fas_err_prev && (e1.ts0_byte[6:0] != `FEDI_FAS_PATTERN);
        consecutive_alignment_error_event <= fas_err_prev && (e1.ts0_byte[6:0] != `FEDI_FAS_PATTERN);
      end
      if (e1_mode && e1.ts0_valid && !e1.fas_frame) begin
        nfas_bit <= e1.ts0_byte[6];
      end
      if (e1_mode && e1.ts16_valid) begin
        mfas_bits <= e1.ts16_byte[7:4];
      end
    end
  end

  // ****************************************************************************
  // Interrupt registers and request output
  // ****************************************************************************
  always_comb begin
    ev_own = '0;
    ev_own[0][`FEDI_W0_SEI] = e1_mode ? consecutive_alignment_error_event : sef_event;
    ev_own[1][`FEDI_W1_DENSITY_VIOLATION_INT] = pdv_event;
    ev_own[3][`FEDI_W3_LCDI] = lcd_event;
    ev_own[3][`FEDI_W3_ONESEC] = one_sec_event;
  end

  always_comb begin
    for (int i = 0; i < NW; i++) begin
      rd_int[i] = rd_hit && bus.page == INT_PAGE[i] && bus.addr == INT_ADDR[i];
      next_int[i] = int_reg[i];
      if (rd_int[i] || (ctl_reg[`FEDI_CTL_INTERRUPT_ACKNOWLEDGE_BIT] != interrupt_acknowledge_bit_prev)) begin
        next_int[i] = `FEDI_RESET_BYTE;
      end
      if (!interrupt_suspend_bit) begin
        next_int[i] = next_int[i] | ((ext_events[i] | ev_own[i]) & mask_reg[i]);
      end
      if (!transmit_all_ones_pin_sync) begin
        next_int[i] = `FEDI_RESET_BYTE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (soft_rst) begin
      for (int i = 0; i < NW; i++) begin
        int_reg[i] <= `FEDI_RESET_BYTE;
      end
      irq_oe <= 1'b0;
    end else begin
      for (int i = 0; i < NW; i++) begin
        int_reg[i] <= next_int[i];
      end
      irq_oe <= !interrupt_suspend_bit && ((|next_int[0]) || (|next_int[1]) || (|next_int[2]) ||
        (|next_int[3]) || (|next_int[4]));
    end
  end

  always_ff @(posedge clk) begin
    irq_n_out <= 1'b0;
  end

  // ****************************************************************************
  // Alarm reporting latch and register reads
  // ****************************************************************************
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      alarm_latch <= `FEDI_RESET_BYTE;
    end else if (rd_hit && bus.page == `FEDI_PAGE_LATCH && bus.addr == `FEDI_ADDR_ALARM_LATCH) begin
      alarm_latch <= alarm_levels;
    end else begin
      alarm_latch <= alarm_latch | alarm_levels;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (bus.page == `FEDI_PAGE_CTL && bus.addr == `FEDI_ADDR_RESET_CTL) begin
      next_rdata = ctl_reg;
    end
    if (bus.page == `FEDI_PAGE_STAT && bus.addr == `FEDI_ADDR_SYNC_STAT) begin
      next_rdata[`FEDI_SYNC_SEF] = sef_toggle;
    end
    if (bus.page == `FEDI_PAGE_STAT && bus.addr == `FEDI_ADDR_ALARM_STAT) begin
      next_rdata[`FEDI_ALM_LOOPBACK_DISABLE_DETECTED] = loopback_disable_detected;
      next_rdata[`FEDI_ALM_LOOPBACK_ENABLE_DETECTED] = loopback_enable_detected;
      next_rdata[`FEDI_ALM_PDV] = pdv_toggle;
    end
    if (bus.page == `FEDI_PAGE_STAT && bus.addr == `FEDI_ADDR_FAS_WORD) begin
      next_rdata = {1'b0, fas_word};
    end
    if (bus.page == `FEDI_PAGE_STAT && bus.addr == `FEDI_ADDR_NFAS_MFAS) begin
      next_rdata = {mfas_bits, nfas_bit, consec_err, 2'b00};
    end
    if (bus.page == `FEDI_PAGE_LATCH && bus.addr == `FEDI_ADDR_ALARM_LATCH) begin
      next_rdata = alarm_latch;
    end
    for (int i = 0; i < NW; i++) begin
      if (bus.page == MASK_PAGE[i] && bus.addr == MASK_ADDR[i]) begin
        next_rdata = mask_reg[i];
      end
      if (bus.page == INT_PAGE[i] && bus.addr == INT_ADDR[i]) begin
        next_rdata = int_reg[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bus_rdata <= 8'h00;
    end else if (rd_hit) begin
      bus_rdata <= next_rdata;
    end
  end

endmodule : fedi_event_irq

`default_nettype wire

/* bench/fedi_event_irq_asserts.sv */
// Concurrent checks on the ports of the event and interrupt block.
`timescale 1ns/1ps
`default_nettype none
`include "fedi_defs.svh"

module fedi_event_irq_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic e1_mode,
  input wire fedi_pkg::fedi_bus_req_s bus,
  input wire fedi_pkg::fedi_line_s line,
  input wire fedi_pkg::fedi_fbit_s t1_fbit,
  input wire fedi_pkg::fedi_e1_s e1,
  input wire fedi_pkg::fedi_words_t ext_events,
  input wire logic [7:0] alarm_levels,
  input wire logic transmit_all_ones_pin_n,
  input wire logic [7:0] bus_rdata,
  input wire logic irq_n_out,
  input wire logic irq_oe
);
  logic [7:0] ctl;
  fedi_pkg::fedi_words_t msk;
  logic [2:0] pin_h;
  logic ctl_wr;
  assign ctl_wr = bus.cs && bus.wr && bus.page == `FEDI_PAGE_CTL;
  always_ff @(posedge clk) begin
    if (reset) begin
      ctl <= 8'h00;
    end else if (ctl_wr && bus.addr == `FEDI_ADDR_RESET_CTL) begin
      ctl <= bus.wdata;
    end
  end
  always_ff @(posedge clk) begin
    if (reset || ctl[7]) begin
      msk <= '0;
    end else if (ctl_wr && bus.addr >= `FEDI_ADDR_MASK0 && bus.addr <= `FEDI_ADDR_MASK3) begin
      msk[3'(bus.addr - `FEDI_ADDR_MASK0)] <= bus.wdata;
    end else if (bus.cs && bus.wr && bus.page == `FEDI_PAGE_HDLC &&
                 bus.addr == `FEDI_ADDR_HDLC_MASK) begin
      msk[4] <= bus.wdata;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_h <= 3'h0;
    end else begin
      pin_h <= {pin_h[1:0], transmit_all_ones_pin_n};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_irq_drive_low: assert property (irq_n_out == 1'b0)
    else $error("request drive level not low");
  chk_event_raise: assert property ((|(ext_events & msk)) && !ctl[6] && !ctl[7] &&
    transmit_all_ones_pin_n && (&pin_h) |=> irq_oe)
    else $error("unmasked event did not raise request");
  chk_masked_quiet: assert property (msk == '0 && $past(msk == '0) && !$past(irq_oe) &&
    !$past(ctl[6]) && !$past(ctl[6], 2) |-> !irq_oe)
    else $error("request raised with all sources masked");
  chk_interrupt_suspend_bit_quiet: assert property (ctl[6] && $past(ctl[6]) |-> !irq_oe)
    else $error("request driven while suspended");
  chk_transmit_all_ones_pin_clear: assert property ((!transmit_all_ones_pin_n)[*4] |=> !irq_oe)
    else $error("request kept while all ones pin low");
  chk_unmapped_zero: assert property (bus.cs && bus.rd && bus.page == 4'h2 |=>
    bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_mask_readback: assert property (bus.cs && bus.rd && bus.page == `FEDI_PAGE_CTL &&
    bus.addr >= `FEDI_ADDR_MASK0 && bus.addr <= `FEDI_ADDR_MASK3 |=>
    bus_rdata == $past(msk[3'(bus.addr - `FEDI_ADDR_MASK0)]))
    else $error("mask word read back wrong");
  chk_rdata_hold: assert property (!(bus.cs && bus.rd) |=> $stable(bus_rdata))
    else $error("read data changed without a read");
endmodule : fedi_event_irq_asserts

bind fedi_event_irq fedi_event_irq_asserts fedi_event_irq_asserts_inst (.clk(clk),
  .reset(reset), .e1_mode(e1_mode), .bus(bus), .line(line), .t1_fbit(t1_fbit), .e1(e1),
  .ext_events(ext_events), .alarm_levels(alarm_levels),
  .transmit_all_ones_pin_n(transmit_all_ones_pin_n), .bus_rdata(bus_rdata),
  .irq_n_out(irq_n_out), .irq_oe(irq_oe));
`default_nettype wire

/* bench/fedi_host.sv */
// Host processor model that makes microport register cycles.
`timescale 1ns/1ps
`default_nettype none

module fedi_host (
  input wire logic clk,
  output var fedi_pkg::fedi_bus_req_s bus
);
  initial begin
    bus = '0;
  end
  // Register cycles carry mask writes and the acknowledge toggle.
  task automatic cyc(input logic w, input logic [3:0] p, input logic [4:0] a,
    input logic [7:0] d);
    @(negedge clk);
    bus = '{cs: 1'b1, rd: !w, wr: w, page: p, addr: a, wdata: d};
    @(negedge clk);
    bus = '{cs: 1'b0, rd: 1'b0, wr: 1'b0, page: ~p, addr: ~a, wdata: ~d};
  endtask : cyc
endmodule : fedi_host
`default_nettype wire

/* bench/test_fedi_event_irq.sv */
// Self-checking bench of the event and interrupt block.
`timescale 1ns/1ps
`default_nettype none
`include "fedi_defs.svh"

module test_fedi_event_irq;
  localparam int SEC = 50;
  localparam logic [3:0] PC = `FEDI_PAGE_CTL;
  localparam logic [3:0] PI = `FEDI_PAGE_LATCH;
  localparam logic [3:0] PH = `FEDI_PAGE_HDLC;
  localparam logic [3:0] PS = `FEDI_PAGE_STAT;
  localparam logic [4:0] M0 = `FEDI_ADDR_MASK0;
  localparam logic [4:0] I0 = `FEDI_ADDR_INT0;
  localparam logic [4:0] CW = `FEDI_ADDR_RESET_CTL;
  logic clk, reset, irq_n_out, irq_oe, rd_pend, pin_n, e1m;
  fedi_pkg::fedi_e1_s e1;
  logic [7:0] bus_rdata;
  logic [3:0] mp, ip;
  logic [4:0] ma, ia;
  fedi_pkg::fedi_bus_req_s bus;
  fedi_pkg::fedi_line_s line;
  fedi_pkg::fedi_fbit_s t1_fbit;
  fedi_pkg::fedi_words_t ext_events;
  int miscompares = 0;
  int cmp_count = 0;
  int n, b;
  integer seed = 32'hB0AC;
  logic [7:0] exp_q[$];

  fedi_host fedi_host_inst (.clk(clk), .bus(bus));
  fedi_event_irq #(.ONE_SEC_CYCLES(SEC), .LOOP_PERSIST_CYCLES(40)) fedi_event_irq_inst (
    .clk(clk), .reset(reset), .e1_mode(e1m), .bus(bus), .line(line), .t1_fbit(t1_fbit),
    .e1(e1), .ext_events(ext_events), .alarm_levels(8'h00),
    .transmit_all_ones_pin_n(pin_n), .bus_rdata(bus_rdata), .irq_n_out(irq_n_out),
    .irq_oe(irq_oe));

  task automatic test_done();
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] y);
    cmp_count++;
    if (y !== x) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, x, y);
    end
  endtask : chk
  task automatic wr(input logic [3:0] p, input logic [4:0] a, input logic [7:0] d);
    fedi_host_inst.cyc(1'b1, p, a, d);
  endtask : wr
  task automatic rd(input logic [3:0] p, input logic [4:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    fedi_host_inst.cyc(1'b0, p, a, 8'h00);
  endtask : rd
  task automatic irq(input logic x);
    chk("irq_oe", {7'h00, x}, {7'h00, irq_oe});
  endtask : irq
  task automatic ev(input int w);
    @(negedge clk);
    ext_events[w] = 8'hFF;
    @(negedge clk);
    ext_events = '0;
  endtask : ev
  task automatic lbit(input logic d);
    @(negedge clk);
    line = '{1'b1, d, 1'b0};
    @(negedge clk);
    line = '{1'b0, !d, 1'b0};
  endtask : lbit
  task automatic fb(input logic er);
    @(negedge clk);
    t1_fbit = '{1'b1, er};
    @(negedge clk);
    t1_fbit = '{1'b0, !er};
  endtask : fb
  task automatic e1f(input logic f, input logic [7:0] t0);
    @(negedge clk);
    e1 = '{1'b1, f, t0, 1'b1, 8'hA0};
    @(negedge clk);
    e1 = '0;
  endtask : e1f
  task automatic wirq();
    while (irq_oe !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
  endtask : wirq

  always @(posedge clk) rd_pend <= bus.cs && bus.rd;
  always @(negedge clk) begin
    if (rd_pend === 1'b1 && exp_q.size() > 0) begin
      chk("bus_rdata", exp_q.pop_front(), bus_rdata);
    end
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #1000000;
    miscompares++;
    test_done();
  end
  initial begin
    reset = 1'b1;
    pin_n = 1'b1;
    line = '0;
    t1_fbit = '0;
    ext_events = '0;
    e1 = '0;
    e1m = 1'b0;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    for (int w = 0; w < 4; w++) rd(PC, M0 + 5'(w), 8'h00);
    rd(PH, `FEDI_ADDR_HDLC_MASK, 8'h00);
    rd(4'h2, 5'h1B, 8'h00);
    for (int w = 0; w < 5; w++) begin
      b = $unsigned($random(seed)) % 8;
      if (w == 3 && b == 3) b = 5;
      mp = w < 4 ? PC : PH;
      ma = w < 4 ? M0 + 5'(w) : `FEDI_ADDR_HDLC_MASK;
      ip = w < 4 ? PI : PH;
      ia = w < 4 ? I0 + 5'(w) : `FEDI_ADDR_HDLC_INT;
      wr(mp, ma, 8'h01 << b);
      rd(mp, ma, 8'h01 << b);
      ev(w);
      irq(1'b1);
      rd(ip, ia, 8'h01 << b);
      irq(1'b0);
      rd(ip, ia, 8'h00);
      wr(mp, ma, 8'h00);
    end
    wr(PC, M0 + 5'd3, 8'h08);
    n = 0;
    wirq();
    irq(1'b1);
    rd(PI, I0 + 5'd3, 8'h08);
    n = 2;
    wirq();
    chk("tick period", 8'(SEC), 8'(n));
    wr(PC, M0 + 5'd3, 8'h00);
    rd(PI, I0 + 5'd3, 8'h08);
    wr(PC, M0, 8'h01);
    wr(PC, CW, 8'h40);
    ev(0);
    irq(1'b0);
    rd(PC, M0, 8'h01);
    wr(PC, CW, 8'h00);
    rd(PI, I0, 8'h00);
    ev(0);
    irq(1'b1);
    wr(PC, CW, 8'h20);
    repeat (2) @(negedge clk);
    irq(1'b0);
    rd(PI, I0, 8'h00);
    ev(0);
    pin_n = 1'b0;
    repeat (4) @(negedge clk);
    irq(1'b0);
    pin_n = 1'b1;
    repeat (3) @(negedge clk);
    rd(PI, I0, 8'h00);
    wr(PC, M0 + 5'd2, 8'($random(seed)));
    wr(PC, CW, 8'h80);
    wr(PC, CW, 8'h00);
    rd(PC, M0 + 5'd2, 8'h00);
    wr(PC, M0 + 5'd1, 8'h01);
    repeat (200) lbit(1'b1);
    repeat (15) lbit(1'b0);
    irq(1'b0);
    lbit(1'b0);
    repeat (3) @(negedge clk);
    irq(1'b1);
    rd(PI, I0 + 5'd1, 8'h01);
    wr(PC, M0, 8'h04);
    fb(1'b1);
    repeat (5) fb(1'b0);
    fb(1'b1);
    repeat (3) @(negedge clk);
    irq(1'b0);
    fb(1'b1);
    repeat (3) @(negedge clk);
    irq(1'b1);
    rd(PI, I0, 8'h04);
    wr(PC, M0 + 5'd3, 8'h10);
    repeat (30) begin
      lbit(1'b0);
      lbit(1'b0);
      lbit(1'b1);
    end
    irq(1'b1);
    rd(PS, `FEDI_ADDR_ALARM_STAT, 8'h05);
    rd(PI, I0 + 5'd3, 8'h10);
    repeat (30) begin
      repeat (4) lbit(1'b0);
      lbit(1'b1);
    end
    rd(PS, `FEDI_ADDR_ALARM_STAT, 8'h06);
    rd(PI, I0 + 5'd3, 8'h10);
    wr(PC, M0 + 5'd3, 8'h00);
    e1m = 1'b1;
    e1f(1'b1, 8'h1B);
    e1f(1'b1, 8'h00);
    e1f(1'b0, 8'h40);
    irq(1'b0);
    e1f(1'b1, 8'h2A);
    repeat (2) @(negedge clk);
    irq(1'b1);
    rd(PI, I0, 8'h04);
    rd(PS, `FEDI_ADDR_FAS_WORD, 8'h2A);
    rd(PS, `FEDI_ADDR_NFAS_MFAS, 8'hAC);
    repeat (3) @(negedge clk);
    test_done();
  end
endmodule : test_fedi_event_irq
`default_nettype wire
